// >>> rtl/tmrc_defines.vh
// Purpose: constants for the temperature monitor register and range control block
// Assumes: 25 MHz system clock
// Notes: offsets are register pointer values on the two-wire link
`ifndef TMRC_DEFINES_VH
`define TMRC_DEFINES_VH
`define TMRC_ADDR_LOCAL 8'h00
`define TMRC_ADDR_REM_HI 8'h01
`define TMRC_ADDR_CFG_RD 8'h03
`define TMRC_ADDR_RATE_RD 8'h04
`define TMRC_ADDR_CFG_WR 8'h09
`define TMRC_ADDR_RATE_WR 8'h0A
`define TMRC_ADDR_REM_LO 8'h10
`define TMRC_PTR_RST 8'h00
`define TMRC_TEMP_RST 8'h00
`define TMRC_CFG_RST 8'h00
`define TMRC_RATE_RST 8'h08
`define TMRC_RATE_MAX 4'hA
`define TMRC_CFG_WMASK 8'hE4
`define TMRC_CFG_MASK_BIT 7
`define TMRC_CFG_STBY_BIT 6
`define TMRC_CFG_PIN6_BIT 5
`define TMRC_CFG_RANGE_BIT 2
`define TMRC_OFFSET_DEG 64
`define TMRC_BIN_MAX 127
// Fastest interval in ns (code 0x0A), slower codes double it
`define TMRC_BASE_NS 15625000
`define TMRC_CLK_NS 40
`define TMRC_BASE_CYC (`TMRC_BASE_NS / `TMRC_CLK_NS)
// Link address value is arbitrary
`define TMRC_DEV_ADDR 7'h2A
`endif

// >>> rtl/tmrc_fmt.v
// Purpose: convert a signed temperature in quarter degrees to register format
// Assumes: input is two's complement, 2 fractional bits
// Notes: purely combinational
`timescale 1ns/1ps
`include "tmrc_defines.vh"
module tmrc_fmt (
  // Measurement
  input wire signed [11:0] temp_i,
  input wire ext_range_i,
  // Result
  output reg [7:0] high_o,
  output reg [7:0] low_o
);
  reg signed [11:0] whole;
  reg signed [11:0] shifted;
  always @* begin
    whole = temp_i >>> 2;
    shifted = whole + 12'sd`TMRC_OFFSET_DEG;
    low_o = {temp_i[1:0], 6'h00}; // RULE_24
    if (ext_range_i) begin
      // Offset binary, saturated to the 0..255 code space
      if (shifted < 12'sd0) begin
        high_o = 8'h00;
        low_o = 8'h00;
      end else if (shifted > 12'sd255) begin
        high_o = 8'hFF;
        low_o = 8'hC0;
      end else begin
        high_o = shifted[7:0]; // RULE_04
      end
    end else begin
      if (whole < 12'sd0) begin
        high_o = 8'h00; // RULE_05
        low_o = 8'h00;
      end else if (whole > 12'sd`TMRC_BIN_MAX) begin
        high_o = 8'h7F; // RULE_05
        low_o = 8'h00;
      end else begin
        high_o = whole[7:0]; // RULE_04
      end
    end
  end
endmodule // tmrc_fmt

// >>> rtl/tmrc_top.v
// Purpose: two-wire register interface, range/format control and conversion pacing
// Assumes: scl/sda arrive asynchronously; measurement path outside supplies results
// Notes: open-drain outputs use oe_n low to pull the line low
`timescale 1ns/1ps
`include "tmrc_defines.vh"
// Function
// RULE_01 - Config bit 2 selects normal or extended range
// RULE_02 - New range valid from next measurement
// RULE_03 - Shorted remote diode keeps last result
// RULE_04 - Binary normally, offset binary plus 64 extended
// RULE_05 - Binary scale clamps to 0 and 127
// RULE_06 - Range change anytime; next result new format
// RULE_07 - Host reprograms limits after range change
// RULE_08 - First write byte loads the pointer
// RULE_09 - Pointer resets to zero, reads local
// RULE_10 - Temperature registers written only by converter
// RULE_11 - Local 0x00, remote 0x01 and 0x10
// RULE_12 - Config read 0x03, write 0x09, reset zero
// RULE_13 - Bit 7 masks interrupt unless second overtemp
// RULE_14 - Bit 6 standby stops conversions
// RULE_15 - Interface and alarms stay active in standby
// RULE_16 - Bit 5 selects pin 6 function
// RULE_17 - Host leaves reserved config bits zero
// RULE_18 - Rate read 0x04, write 0x0A, low nibble
// RULE_19 - Rate codes halve interval, 16 s to 15.5 ms; the code's fastest interval is 15.625 ms
// RULE_20 - Each interval converts both channels
// RULE_21 - Host writes zero to upper rate bits
// RULE_22 - Rate register resets to 0x08
// RULE_23 - Low byte read freezes high byte
// RULE_24 - Remote low byte holds two fraction bits
// RULE_25 - Conversion in progress completes before standby
module tmrc_top #(
  parameter [31:0] BASE_CYC = `TMRC_BASE_CYC,
  parameter [6:0] DEV_ADDR = `TMRC_DEV_ADDR
) (
  // Clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // Two-wire link, open drain
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_n_o,
  // Measurement path
  output wire conv_start_o,
  output wire conv_channel_o,
  input wire conv_done_i,
  input wire signed [11:0] conv_temp_i,
  input wire remote_short_i,
  // Alarm sources from limit logic
  input wire irq_event_i,
  input wire overtemp_high_i,
  // Pin 6 and mode
  output wire pin6_o,
  output wire pin6_oe_n_o,
  output wire ext_range_o,
  output wire standby_o
);
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_LOCAL = 4'b0010;
  localparam [3:0] S_REMOTE = 4'b0100;
  localparam [3:0] S_START2 = 4'b1000;
  localparam [4:0] L_IDLE = 5'b00001;
  localparam [4:0] L_ADDR = 5'b00010;
  localparam [4:0] L_ACK = 5'b00100;
  localparam [4:0] L_WBYTE = 5'b01000;
  localparam [4:0] L_RBYTE = 5'b10000;

  reg [7:0] ptr_q;
  reg [7:0] local_q;
  reg [7:0] rem_hi_q;
  reg [7:0] rem_lo_q;
  reg [7:0] cfg_q;
  reg [7:0] rate_q;
  reg freeze_q;
  reg [3:0] conv_q;
  reg start_q;
  reg chan_q;
  reg [31:0] tick_cnt_q;
  reg [2:0] scl_s_q;
  reg [2:0] sda_s_q;
  reg [4:0] lst_q;
  reg [3:0] bit_q;
  reg [7:0] shift_q;
  reg rd_q;
  reg first_q;
  reg sda_drv_q;
  reg [7:0] tx_q;

  wire [7:0] fmt_hi;
  wire [7:0] fmt_lo;
  wire ext_range = cfg_q[`TMRC_CFG_RANGE_BIT];
  wire standby = cfg_q[`TMRC_CFG_STBY_BIT];
  wire scl_rise = scl_s_q[1] & ~scl_s_q[2];
  wire scl_fall = ~scl_s_q[1] & scl_s_q[2];
  wire start_cond = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
  wire stop_cond = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];

  // Interval length for a rate code; reserved codes fall back to the fastest
  function [31:0] interval_cyc;
    input [3:0] code;
    input [31:0] base;
    reg [3:0] c;
    begin
      c = (code > `TMRC_RATE_MAX) ? `TMRC_RATE_MAX : code;
      interval_cyc = base << (`TMRC_RATE_MAX - c); // RULE_19
    end
  endfunction

  // Register read decode
  function [7:0] reg_read;
    input [7:0] a;
    input [7:0] l;
    input [7:0] h;
    input [7:0] lo;
    input [7:0] c;
    input [7:0] r;
    begin
      case (a)
        `TMRC_ADDR_LOCAL: reg_read = l; // RULE_11
        `TMRC_ADDR_REM_HI: reg_read = h;
        `TMRC_ADDR_REM_LO: reg_read = lo;
        `TMRC_ADDR_CFG_RD: reg_read = c; // RULE_12
        `TMRC_ADDR_RATE_RD: reg_read = r; // RULE_18
        default: reg_read = 8'h00;
      endcase
    end
  endfunction

  tmrc_fmt u_fmt (
    .temp_i(conv_temp_i),
    .ext_range_i(ext_range),
    .high_o(fmt_hi),
    .low_o(fmt_lo)
  );

  // Two-stage synchronisers; third stage only for edge detection
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_i};
      sda_s_q <= {sda_s_q[1:0], sda_i};
    end
  end

  // Conversion pacing: local then remote each interval
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conv_q <= S_IDLE;
      tick_cnt_q <= 32'h0;
      start_q <= 1'b0;
      chan_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (tick_cnt_q != 32'h0) begin
        tick_cnt_q <= tick_cnt_q - 32'h1;
      end
      case (conv_q)
        S_IDLE: begin
          // Standby only gates new intervals, so a running one finishes
          if (!standby && tick_cnt_q == 32'h0) begin // RULE_14 RULE_25
            tick_cnt_q <= interval_cyc(rate_q[3:0], BASE_CYC) - 32'h1;
            start_q <= 1'b1;
            chan_q <= 1'b0;
            conv_q <= S_LOCAL; // RULE_20
          end
        end
        S_LOCAL: begin
          if (conv_done_i) begin
            conv_q <= S_START2;
          end
        end
        S_START2: begin
          start_q <= 1'b1;
          chan_q <= 1'b1;
          conv_q <= S_REMOTE; // RULE_20
        end
        S_REMOTE: begin
          if (conv_done_i) begin
            conv_q <= S_IDLE;
          end
        end
        default: conv_q <= S_IDLE;
      endcase
    end
  end

  // Result registers; format follows range at the moment the result lands
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      local_q <= `TMRC_TEMP_RST;
      rem_hi_q <= `TMRC_TEMP_RST;
      rem_lo_q <= `TMRC_TEMP_RST;
    end else if (conv_done_i) begin // RULE_10
      if (conv_q == S_LOCAL) begin
        local_q <= fmt_hi; // RULE_01 RULE_02 RULE_06
      end else if (conv_q == S_REMOTE && !remote_short_i) begin // RULE_03
        rem_lo_q <= fmt_lo; // RULE_24
        if (!freeze_q) begin
          rem_hi_q <= fmt_hi; // RULE_23
        end
      end
    end
  end

  // Two-wire slave: pointer, writes and reads
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lst_q <= L_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      rd_q <= 1'b0;
      first_q <= 1'b0;
      sda_drv_q <= 1'b0;
      tx_q <= 8'h00;
      ptr_q <= `TMRC_PTR_RST; // RULE_09
      cfg_q <= `TMRC_CFG_RST; // RULE_12
      rate_q <= `TMRC_RATE_RST; // RULE_22
      freeze_q <= 1'b0;
    end else if (start_cond) begin
      lst_q <= L_ADDR;
      bit_q <= 4'h0;
      sda_drv_q <= 1'b0;
    end else if (stop_cond) begin
      lst_q <= L_IDLE;
      sda_drv_q <= 1'b0;
    end else begin
      case (lst_q)
        L_IDLE: sda_drv_q <= 1'b0;
        L_ADDR, L_WBYTE: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s_q[1]};
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            bit_q <= 4'h0;
            if (lst_q == L_ADDR) begin
              if (shift_q[7:1] == DEV_ADDR) begin
                rd_q <= shift_q[0];
                first_q <= 1'b1;
                sda_drv_q <= 1'b1;
                lst_q <= L_ACK;
              end else begin
                lst_q <= L_IDLE;
              end
            end else begin
              sda_drv_q <= 1'b1;
              lst_q <= L_ACK;
              if (first_q) begin
                ptr_q <= shift_q; // RULE_08
                first_q <= 1'b0;
              end else if (ptr_q == `TMRC_ADDR_CFG_WR) begin
                // Reserved bits are held at zero; alarms follow at once
                cfg_q <= shift_q & `TMRC_CFG_WMASK; // RULE_13 RULE_15 RULE_16
              end else if (ptr_q == `TMRC_ADDR_RATE_WR) begin
                rate_q <= {4'h0, shift_q[3:0]}; // RULE_18
              end
            end
          end
        end
        L_ACK: begin
          if (scl_fall) begin
            if (rd_q) begin
              tx_q <= reg_read(ptr_q, local_q, rem_hi_q, rem_lo_q, cfg_q, rate_q); // RULE_08
              if (ptr_q == `TMRC_ADDR_REM_LO) begin
                freeze_q <= 1'b1; // RULE_23
              end else if (ptr_q == `TMRC_ADDR_REM_HI) begin
                freeze_q <= 1'b0; // RULE_23
              end
              sda_drv_q <= 1'b1;
              lst_q <= L_RBYTE;
            end else begin
              sda_drv_q <= 1'b0;
              lst_q <= L_WBYTE;
            end
          end
        end
        L_RBYTE: begin
          if (scl_fall) begin
            if (bit_q == 4'h7) begin
              sda_drv_q <= 1'b0;
              bit_q <= 4'h8;
            end else if (bit_q == 4'h8) begin
              // Master ack slot done; next byte shifts on from tx_q without a reload
              bit_q <= 4'h0;
              sda_drv_q <= 1'b1;
            end else begin
              tx_q <= {tx_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
            end
          end else if (scl_rise && bit_q == 4'h8 && sda_s_q[1]) begin
            lst_q <= L_IDLE;
          end
        end
        default: lst_q <= L_IDLE;
      endcase
    end
  end

  // Pull low for ack, or for a zero data bit while sending
  wire pull_low = (lst_q == L_ACK) ? sda_drv_q : (sda_drv_q & ~tx_q[7]);
  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~pull_low;

  // Pin 6: interrupt with mask, or second overtemperature ignoring mask
  wire pin6_active = cfg_q[`TMRC_CFG_PIN6_BIT] ? overtemp_high_i : // RULE_16
    (irq_event_i & ~cfg_q[`TMRC_CFG_MASK_BIT]); // RULE_13
  assign pin6_o = 1'b0;
  assign pin6_oe_n_o = ~pin6_active; // RULE_15

  assign conv_start_o = start_q;
  assign conv_channel_o = chan_q;
  assign ext_range_o = ext_range;
  assign standby_o = standby;
endmodule // tmrc_top

// >>> tb/tmrc_top_monitor.sv
// Purpose: port checker for tmrc_top
// Assumes: BASE_CYC equals the bound instance
// Notes: config bits 7 and 5 are not ports, so pin 6 is left to the bench
`timescale 1ns/1ps
module tmrc_chk #(
  parameter [31:0] BASE_CYC = 32'd20
) (
  // Clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // Watched
  input wire scl_i,
  input wire sda_oe_n_o,
  input wire conv_start_o,
  input wire conv_channel_o,
  input wire conv_done_i,
  input wire standby_o
);
  reg [31:0] gap_q;
  wire loc = conv_start_o & ~conv_channel_o;
  // Saturates so a long standby cannot wrap it
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) gap_q <= 32'h0;
    else if (loc) gap_q <= 32'h1;
    else if (gap_q != 32'h0 && ~&gap_q) gap_q <= gap_q + 32'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_rst_quiet: assert property (disable iff (1'b0)
    sys_rst_i |-> sda_oe_n_o && !conv_start_o) else $error("output active in reset");
  chk_start_one: assert property (conv_start_o |=> !conv_start_o)
    else $error("start too long");
  chk_remote_next: assert property (conv_done_i && !conv_channel_o |->
    ##[1:3] (conv_start_o && conv_channel_o)) else $error("no remote start");
  chk_remote_cause: assert property (conv_start_o && conv_channel_o |->
    $past(conv_done_i) || $past(conv_done_i, 2) || $past(conv_done_i, 3))
    else $error("remote start without local result");
  chk_chan_hold: assert property (!conv_start_o |-> $stable(conv_channel_o))
    else $error("channel moved");
  chk_stby_halt: assert property (loc |-> !$past(standby_o))
    else $error("start in standby");
  chk_gap_min: assert property (loc && gap_q != 32'h0 |-> gap_q >= BASE_CYC)
    else $error("interval too short");
  chk_sda_scl_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
    else $error("sda moved with scl high");
  cov_remote: cover property (conv_start_o && conv_channel_o);
  cov_stby: cover property ($rose(standby_o));
  cov_ack: cover property ($fell(sda_oe_n_o));
endmodule // tmrc_chk

bind tmrc_top tmrc_chk #(.BASE_CYC(BASE_CYC)) tmrc_chk_inst (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_oe_n_o(sda_oe_n_o), .conv_start_o(conv_start_o),
  .conv_channel_o(conv_channel_o), .conv_done_i(conv_done_i), .standby_o(standby_o));

// >>> tb/tmrc_host.sv
// Purpose: two-wire host model
// Assumes: 8 clocks per bit
// Notes: scl idles high between frames
`timescale 1ns/1ps
module tmrc_host #(
  parameter [6:0] DEV_ADDR = 7'h2A // Arbitrary link address
) (
  // Clock
  input wire clk_i,
  // Link
  input wire sda_i,
  output reg scl_o,
  output reg sda_o
);
  integer nack_cnt = 0;
  initial {scl_o, sda_o} = 2'b11;
  task wt(input integer n);
    repeat (n) @(negedge clk_i);
  endtask
  // a=1 start, a=0 stop
  task cond(input a);
    begin
      sda_o = a;
      wt(2);
      scl_o = 1'b1;
      wt(2);
      sda_o = ~a;
      wt(2);
      scl_o = ~a;
      wt(2);
    end
  endtask
  // Ninth bit is the ack slot; host sends 1 there
  task xfer(input [7:0] b, input ack, output [7:0] r);
    reg [8:0] sh;
    integer i;
    begin
      sh = {b, 1'b1};
      for (i = 8; i >= 0; i = i - 1) begin
        sda_o = sh[i];
        wt(2);
        scl_o = 1'b1;
        wt(4);
        sh[i] = sda_i;
        scl_o = 1'b0;
        wt(2);
      end
      r = sh[8:1];
      if (sh[0] !== ack) nack_cnt = nack_cnt + 1;
    end
  endtask
  task wr(input [7:0] p, input [7:0] d);
    reg [7:0] r;
    begin
      cond(1'b1);
      xfer({DEV_ADDR, 1'b0}, 1'b0, r);
      xfer(p, 1'b0, r);
      xfer(d, 1'b0, r);
      cond(1'b0);
    end
  endtask
  task rd(input [7:0] p, input set_p, output [7:0] d);
    reg [7:0] r;
    begin
      if (set_p) begin
        cond(1'b1);
        xfer({DEV_ADDR, 1'b0}, 1'b0, r);
        xfer(p, 1'b0, r);
      end
      cond(1'b1);
      xfer({DEV_ADDR, 1'b1}, 1'b0, r);
      xfer(8'hFF, 1'b1, d);
      cond(1'b0);
    end
  endtask
endmodule // tmrc_host

// >>> tb/tmrc_top_tb.sv
// Purpose: self-checking bench for tmrc_top
// Assumes: BASE_CYC of 20 shortens intervals
// Notes: results answer each start after three cycles
`timescale 1ns/1ps
`include "tmrc_defines.vh"
module tmrc_top_tb;
  reg clk_i, sys_rst_i, conv_done_i, remote_short_i, irq_event_i, overtemp_high_i;
  reg signed [11:0] conv_temp_i, t_loc, t_rem;
  reg [7:0] rv;
  reg [15:0] e;
  integer n_mismatch = 0, cmp_count = 0, n_start = 0, k;
  wire scl, sda_h, sda_o, sda_oe_n_o, conv_start_o, conv_channel_o;
  wire pin6_o, pin6_oe_n_o, ext_range_o, standby_o;
  wire sda = sda_h & (sda_oe_n_o | sda_o);
  tmrc_top #(.BASE_CYC(32'd20)) tmrc_top_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o), .conv_done_i(conv_done_i),
    .conv_temp_i(conv_temp_i), .remote_short_i(remote_short_i), .irq_event_i(irq_event_i),
    .overtemp_high_i(overtemp_high_i), .pin6_o(pin6_o), .pin6_oe_n_o(pin6_oe_n_o),
    .ext_range_o(ext_range_o), .standby_o(standby_o));
  tmrc_host #(.DEV_ADDR(`TMRC_DEV_ADDR)) tmrc_host_inst (.clk_i(clk_i), .sda_i(sda),
    .scl_o(scl), .sda_o(sda_h));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (conv_start_o) n_start <= n_start + 1;
  initial begin
    conv_done_i = 1'b0;
    conv_temp_i = 12'sh000;
    forever begin
      @(negedge clk_i);
      if (conv_start_o) begin
        repeat (2) @(negedge clk_i);
        conv_temp_i = conv_channel_o ? t_rem : t_loc;
        conv_done_i = 1'b1;
        @(negedge clk_i);
        conv_done_i = 1'b0;
      end
    end
  end
  function [15:0] fmt(input signed [11:0] t, input x);
    integer d;
    begin
      d = (t >>> 2) + (x ? 64 : 0);
      if (d < 0) fmt = 16'h0000;
      else if (d > (x ? 255 : 127)) fmt = x ? 16'hFFC0 : 16'h7F00;
      else fmt = {d[7:0], t[1:0], 6'h00};
    end
  endfunction
  task cmp(input string nm, input [7:0] x, input [7:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== x) begin
        n_mismatch = n_mismatch + 1;
        $display("Error %s expected %h seen %h", nm, x, g);
      end
    end
  endtask
  task chk_rd(input [7:0] p, input [7:0] x);
    begin
      tmrc_host_inst.rd(p, 1'b1, rv);
      cmp($sformatf("reg %h", p), x, rv);
    end
  endtask
  task chk_t(input x);
    begin
      e = fmt(t_loc, x);
      chk_rd(`TMRC_ADDR_LOCAL, e[15:8]);
      e = fmt(t_rem, x);
      chk_rd(`TMRC_ADDR_REM_LO, e[7:0]);
      chk_rd(`TMRC_ADDR_REM_HI, e[15:8]);
    end
  endtask
  task gap(input [7:0] x);
    integer n;
    begin
      n = 0;
      while (!(conv_start_o && !conv_channel_o)) @(negedge clk_i);
      do begin
        @(negedge clk_i);
        n = n + 1;
      end while (!(conv_start_o && !conv_channel_o));
      cmp("interval", x, n[7:0]);
    end
  endtask
  task final_report;
    begin
      $display("Compared %0d mismatched %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch = n_mismatch + 1;
    final_report;
  end
  initial begin
    {sys_rst_i, remote_short_i, irq_event_i, overtemp_high_i} = 4'hC;
    t_loc = 12'sd100;
    t_rem = 12'sd203;
    repeat (10) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (100) @(negedge clk_i);
    // Remote shorted: its bytes keep the reset value
    tmrc_host_inst.rd(8'h00, 1'b0, rv);
    e = fmt(t_loc, 1'b0);
    cmp("unpointed read", e[15:8], rv);
    gap(8'd80);
    // Low byte first, so the high byte read releases the freeze again
    chk_rd(`TMRC_ADDR_REM_LO, `TMRC_TEMP_RST);
    chk_rd(`TMRC_ADDR_REM_HI, `TMRC_TEMP_RST);
    chk_rd(`TMRC_ADDR_CFG_RD, `TMRC_CFG_RST);
    chk_rd(`TMRC_ADDR_RATE_RD, `TMRC_RATE_RST);
    remote_short_i = 1'b0;
    repeat (100) @(negedge clk_i);
    chk_t(1'b0);
    chk_rd(`TMRC_ADDR_REM_LO, 8'hC0);
    t_rem = 12'sd400;
    repeat (200) @(negedge clk_i);
    chk_rd(`TMRC_ADDR_REM_HI, 8'h32);
    t_loc = -12'sd40;
    t_rem = 12'sd600;
    chk_t(1'b0);
    tmrc_host_inst.wr(`TMRC_ADDR_CFG_WR, 8'h04);
    cmp("range", 8'h01, {7'h0, ext_range_o});
    t_loc = -12'sd220;
    t_rem = -12'sd1;
    repeat (100) @(negedge clk_i);
    chk_t(1'b1);
    // Limits outside are taken as reprogrammed in the new format
    irq_event_i = 1'b1;
    @(negedge clk_i);
    cmp("pin6 alert", 8'h00, {7'h0, pin6_oe_n_o});
    cmp("pin6 level", 8'h00, {7'h0, pin6_o});
    tmrc_host_inst.wr(`TMRC_ADDR_CFG_WR, 8'h84);
    cmp("pin6 masked", 8'h01, {7'h0, pin6_oe_n_o});
    overtemp_high_i = 1'b1;
    tmrc_host_inst.wr(`TMRC_ADDR_CFG_WR, 8'hE4);
    cmp("pin6 overtemp", 8'h00, {7'h0, pin6_oe_n_o});
    cmp("standby", 8'h01, {7'h0, standby_o});
    // Let a conversion in flight finish first
    repeat (20) @(negedge clk_i);
    k = n_start;
    tmrc_host_inst.wr(`TMRC_ADDR_LOCAL, 8'h55);
    chk_rd(`TMRC_ADDR_LOCAL, 8'h09);
    chk_rd(`TMRC_ADDR_CFG_RD, 8'hE4);
    chk_rd(`TMRC_ADDR_CFG_WR, 8'h00);
    cmp("standby starts", 8'h00, n_start[7:0] - k[7:0]);
    overtemp_high_i = 1'b0;
    @(negedge clk_i);
    cmp("pin6 clear", 8'h01, {7'h0, pin6_oe_n_o});
    tmrc_host_inst.wr(`TMRC_ADDR_CFG_WR, 8'h00);
    cmp("run", 8'h00, {6'h0, ext_range_o, standby_o});
    tmrc_host_inst.wr(`TMRC_ADDR_RATE_WR, 8'h0A);
    chk_rd(`TMRC_ADDR_RATE_RD, 8'h0A);
    gap(8'd20);
    cmp("acks", 8'h00, tmrc_host_inst.nack_cnt[7:0]);
    cmp("sda level", 8'h00, {7'h0, sda_o});
    final_report;
  end
endmodule // tmrc_top_tb
